// ===== ssr_top.sv
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_cfg.svh"

// Functional notes
// - Running lockout timer refuses start, shows lockout message, remaining time readable.
// - Correct password releases parameter lock and shows accepted message.
// - Wrong password shows error message and keeps the lock.
// - Accepted new value is stored as active setting with change message.
// - Default restore loads defaults into all parameters and shows defaults message.
// - Start while tripped shows tripped; fault shown after start withdrawn.
// - Thermal capacity shown 000..100, falls when loaded, rises while cooling.
// - Trip reset level learned from capacity used by successful starts; readable.
// - Writing 2 to clear function zeroes thermal register and lockouts.
// - Two ramp sets chosen by external contact; contact selects ramp two.
// - Ramp type 1..4 decodes voltage or current for each ramp.
// - Each ramp set has own voltage, current, time and limit values.
// - Voltage ramp rises to full over ramp time; limit at 600% inert.
// - Voltage ramp holds while current at limit, resumes below it.
// - Current limit overrides ramp time; time still sets slope.
// - Current ramp rises linearly to limit, closed loop on measured current.
// - Current ramp starts from initial current, never initial voltage.
// - Maximum initial level with minimum time steps current to the limit.
// - Current limiting ends at full speed or on thermal trip.
// - Current limit below 200% is not accepted.
// - Full speed before ramp end ends the ramp early.
module ssr_top
    import ssr_pkg::*;
#(
    parameter int          TICK_CYCLES = `SSR_TICK_CYC,
    parameter logic [15:0] PASSWORD    = 16'h5a3c  // Arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic        start_cmd_i,
    input  wire logic        ramp2_sel_i,
    input  wire logic        at_speed_i,
    input  wire logic [9:0]  motor_current_i,
    output logic [15:0]      voltage_cmd_o,
    output logic             current_limit_o,
    output logic             running_o,
    output logic             trip_o,
    output logic [3:0]       status_msg_o,
    output logic [6:0]       thermal_cap_o
);

    ssr_state_reg_t s_q;
    ssr_state_reg_t s_d;

    logic              acc;
    logic              wr;
    logic              wr_cfg;
    logic              tick;
    logic              start_s;
    logic              sel_s;
    logic              atspd_s;
    logic              lock_any;
    logic              at_limit;
    logic              vt_sel;
    logic              step_sel;
    ssr_ramp_t         rs;
    logic [20:0]       sum;
    logic signed [22:0] err;
    logic signed [22:0] vnext;

    assign start_s  = s_q.sy2[2];
    assign sel_s    = s_q.sy2[1];
    assign atspd_s  = s_q.sy2[0];
    assign lock_any = |s_q.lock;
    assign tick     = (s_q.tick == 32'(TICK_CYCLES - 1));
    assign acc      = cyc_i & stb_i & ~s_q.ack;
    // Partial-lane writes are ignored; every field but the ramp type is wider than a byte
    assign wr       = acc & we_i & (sel_i == 4'hf);
    assign wr_cfg   = wr & ~s_q.locked & (s_q.st == SSR_IDLE);
    // Set chosen at start stays in force; a contact change mid-ramp is ignored
    assign rs       = ((s_q.st == SSR_IDLE) ? sel_s : s_q.sel2) ? s_q.ramp[1]
                                                                 : s_q.ramp[0];
    // Ramp one is voltage for types 1 and 3, ramp two for 1 and 4
    assign vt_sel   = sel_s ? (s_q.rtype == 3'h1 || s_q.rtype == 3'h4)
                            : (s_q.rtype == 3'h1 || s_q.rtype == 3'h3);
    assign step_sel = (rs.rtime == `SSR_TIME_MIN) &&
                      (vt_sel ? (rs.iv >= `SSR_FULL) : (rs.ic >= rs.cl));
    assign at_limit = (motor_current_i >= rs.cl) && (rs.cl < `SSR_CL_MAX);

    always_comb begin
        s_d    = s_q;
        sum    = '0;
        err    = '0;
        vnext  = '0;
        s_d.ack = acc;
        s_d.sy1 = {start_cmd_i, ramp2_sel_i, at_speed_i};
        s_d.sy2 = s_q.sy1;
        s_d.tick = tick ? 32'h0 : s_q.tick + 32'h1;

        // Register writes
        if (wr) begin
            case (adr_i)
                `SSR_OFF_TYPE: begin
                    if (wr_cfg && dat_i[2:0] >= 3'h1 && dat_i[2:0] <= 3'h4
                        && dat_i[31:3] == '0) begin
                        s_d.rtype = dat_i[2:0];
                        s_d.msg   = SSR_MSG_CHANGE_OK;
                    end else begin
                        s_d.msg = SSR_MSG_INHIBIT;
                    end
                end
                `SSR_OFF_R1_IV, `SSR_OFF_R2_IV, `SSR_OFF_R1_IC, `SSR_OFF_R2_IC: begin
                    if (wr_cfg && dat_i[31:10] == '0) begin
                        if (adr_i[3:2] == 2'h1)
                            s_d.ramp[adr_i[4]].iv = dat_i[9:0];
                        else
                            s_d.ramp[adr_i[4]].ic = dat_i[9:0];
                        s_d.msg = SSR_MSG_CHANGE_OK;
                    end else begin
                        s_d.msg = SSR_MSG_INHIBIT;
                    end
                end
                `SSR_OFF_R1_TIME, `SSR_OFF_R2_TIME: begin
                    if (wr_cfg && dat_i[15:0] >= `SSR_TIME_MIN && dat_i[31:16] == '0) begin
                        s_d.ramp[adr_i[4]].rtime = dat_i[15:0];
                        s_d.msg = SSR_MSG_CHANGE_OK;
                    end else begin
                        s_d.msg = SSR_MSG_INHIBIT;
                    end
                end
                `SSR_OFF_R1_CL, `SSR_OFF_R2_CL: begin
                    // Below 200% most motors never break away
                    if (wr_cfg && dat_i[31:10] == '0 && dat_i[9:0] >= `SSR_CL_MIN
                        && dat_i[9:0] <= `SSR_CL_MAX) begin
                        s_d.ramp[adr_i[5]].cl = dat_i[9:0];
                        s_d.msg = SSR_MSG_CHANGE_OK;
                    end else begin
                        s_d.msg = SSR_MSG_INHIBIT;
                    end
                end
                `SSR_OFF_DEFCLR: begin
                    if (wr_cfg && dat_i == `SSR_DEFCLR_RESTORE) begin
                        s_d.rtype = `SSR_DEF_TYPE;
                        for (int i = 0; i < 2; i++) begin
                            s_d.ramp[i] = '{`SSR_DEF_IV, `SSR_DEF_IC, `SSR_DEF_TIME, `SSR_DEF_CL};
                        end
                        s_d.msg = SSR_MSG_DEFAULTS;
                    end else if (wr_cfg && dat_i == `SSR_DEFCLR_CLEAR) begin
                        s_d.heat = '0;
                        s_d.lock = '0;
                        s_d.msg  = SSR_MSG_CLEARED;
                    end else begin
                        s_d.msg = SSR_MSG_INHIBIT;
                    end
                end
                `SSR_OFF_PASSWORD: begin
                    if (dat_i == {16'h0, PASSWORD}) begin
                        s_d.locked = 1'b0;
                        s_d.msg    = SSR_MSG_PASS_OK;
                    end else begin
                        s_d.locked = 1'b1;
                        s_d.msg    = SSR_MSG_PASS_ERR;
                    end
                end
                `SSR_OFF_LOCK0, `SSR_OFF_LOCK1, `SSR_OFF_LOCK2: begin
                    s_d.lock[2'(adr_i[5:2] - 4'hb)] = dat_i[15:0];
                end
                `SSR_OFF_TRIPRST: begin
                    // Reset only once enough capacity has come back
                    if (s_q.trip && (7'd100 - s_q.heat) >= s_q.req_cap) begin
                        s_d.trip = 1'b0;
                        s_d.msg  = SSR_MSG_NONE;
                    end else begin
                        s_d.msg = SSR_MSG_INHIBIT;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads, taken from state before this cycle's write
        if (acc && !we_i) begin
            case (adr_i)
                `SSR_OFF_TYPE:     s_d.rdat = {29'h0, s_q.rtype};
                `SSR_OFF_R1_IV:    s_d.rdat = {22'h0, s_q.ramp[0].iv};
                `SSR_OFF_R1_IC:    s_d.rdat = {22'h0, s_q.ramp[0].ic};
                `SSR_OFF_R1_TIME:  s_d.rdat = {16'h0, s_q.ramp[0].rtime};
                `SSR_OFF_R1_CL:    s_d.rdat = {22'h0, s_q.ramp[0].cl};
                `SSR_OFF_R2_IV:    s_d.rdat = {22'h0, s_q.ramp[1].iv};
                `SSR_OFF_R2_IC:    s_d.rdat = {22'h0, s_q.ramp[1].ic};
                `SSR_OFF_R2_TIME:  s_d.rdat = {16'h0, s_q.ramp[1].rtime};
                `SSR_OFF_R2_CL:    s_d.rdat = {22'h0, s_q.ramp[1].cl};
                `SSR_OFF_LOCK0:    s_d.rdat = {16'h0, s_q.lock[0]};
                `SSR_OFF_LOCK1:    s_d.rdat = {16'h0, s_q.lock[1]};
                `SSR_OFF_LOCK2:    s_d.rdat = {16'h0, s_q.lock[2]};
                `SSR_OFF_STATUS:   s_d.rdat = {19'h0, s_q.vtype, s_q.sel2, s_q.climit,
                                               s_q.trip, s_q.locked, 2'h0, s_q.st, s_q.msg};
                `SSR_OFF_THERMAL:  s_d.rdat = {17'h0, s_q.req_cap, 1'b0,
                                               7'd100 - s_q.heat};
                `SSR_OFF_OUTPUT:   s_d.rdat = {12'h0, s_q.volt};
                default:           s_d.rdat = 32'h0;
            endcase
        end

        if (tick) begin
            for (int i = 0; i < 3; i++) begin
                // Count from this cycle's value so a clear or reload is not undone
                if (s_d.lock[i] != 16'h0)
                    s_d.lock[i] = s_d.lock[i] - 16'h1;
            end
            // Heat builds above full load while energised, bleeds off when stopped
            if (s_q.st != SSR_IDLE && motor_current_i > `SSR_FULL) begin
                if (s_q.heat < 7'd100)
                    s_d.heat = s_q.heat + 7'h1;
                if (s_q.heat >= 7'd99)
                    s_d.trip = 1'b1;
            end else if (s_q.st == SSR_IDLE && s_d.heat != 7'h0) begin
                s_d.heat = s_d.heat - 7'h1;
            end
        end

        case (s_q.st)
            SSR_IDLE: begin
                s_d.volt   = '0;
                s_d.climit = 1'b0;
                if (start_s && lock_any) begin
                    s_d.msg = SSR_MSG_LOCKOUT;
                end else if (start_s && s_q.trip) begin
                    s_d.msg = SSR_MSG_TRIPPED;
                end else if (s_q.msg == SSR_MSG_TRIPPED) begin
                    s_d.msg = SSR_MSG_FAULT;
                end else if (start_s && !wr) begin
                    s_d.st         = SSR_RAMP;
                    s_d.sel2       = sel_s;
                    s_d.vtype      = vt_sel;
                    s_d.cmode      = step_sel | ~vt_sel;
                    s_d.heat_start = s_q.heat;
                    if (step_sel) begin
                        s_d.rref = {rs.cl, 10'h0} >> 2;
                        s_d.tgt  = {rs.cl, 10'h0} >> 2;
                        s_d.inc  = '0;
                    end else if (vt_sel) begin
                        s_d.rref = {2'h0, rs.iv, 8'h0};
                        s_d.volt = {2'h0, rs.iv, 8'h0};
                        s_d.tgt  = {2'h0, `SSR_FULL, 8'h0};
                        // Slope from span over time, even if the limit cuts in later
                        s_d.inc  = 20'({2'h0, `SSR_FULL - rs.iv, 8'h0} / rs.rtime);
                    end else begin
                        s_d.rref = (rs.ic > rs.cl) ? {2'h0, rs.cl, 8'h0}
                                                   : {2'h0, rs.ic, 8'h0};
                        s_d.tgt  = {2'h0, rs.cl, 8'h0};
                        s_d.inc  = (rs.ic > rs.cl) ? 20'h0
                                 : 20'({2'h0, rs.cl - rs.ic, 8'h0} / rs.rtime);
                    end
                end
            end
            SSR_RAMP: begin
                if (!start_s || s_q.trip) begin
                    s_d.st     = SSR_IDLE;
                    s_d.volt   = '0;
                    s_d.climit = 1'b0;
                end else if (atspd_s) begin
                    s_d.st     = SSR_RUN;
                    s_d.volt   = {2'h0, `SSR_FULL, 8'h0};
                    s_d.climit = 1'b0;
                    s_d.req_cap = s_q.heat - s_q.heat_start;
                end else if (!s_q.cmode) begin
                    s_d.climit = at_limit;
                    if (tick && !at_limit) begin
                        sum = {1'b0, s_q.volt} + {1'b0, s_q.inc};
                        s_d.volt = (sum >= {1'b0, s_q.tgt}) ? s_q.tgt : sum[19:0];
                    end
                end else begin
                    s_d.climit = (s_q.rref == s_q.tgt);
                    if (tick) begin
                        sum = {1'b0, s_q.rref} + {1'b0, s_q.inc};
                        s_d.rref = (sum >= {1'b0, s_q.tgt}) ? s_q.tgt : sum[19:0];
                        // Integrating regulator: output moves with current error
                        err   = $signed({3'h0, s_q.rref}) - $signed({5'h0, motor_current_i, 8'h0});
                        vnext = $signed({3'h0, s_q.volt}) + (err >>> `SSR_KP_SHIFT);
                        if (vnext < 0)
                            s_d.volt = '0;
                        else if (vnext > $signed({5'h0, `SSR_FULL, 8'h0}))
                            s_d.volt = {2'h0, `SSR_FULL, 8'h0};
                        else
                            s_d.volt = vnext[19:0];
                    end
                end
            end
            SSR_RUN: begin
                if (!start_s || s_q.trip) begin
                    s_d.st   = SSR_IDLE;
                    s_d.volt = '0;
                end
            end
            default: s_d.st = SSR_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q        <= '0;
            s_q.st     <= SSR_IDLE;
            s_q.msg    <= SSR_MSG_NONE;
            s_q.rtype  <= `SSR_DEF_TYPE;
            s_q.ramp   <= {2{`SSR_DEF_IV, `SSR_DEF_IC, `SSR_DEF_TIME, `SSR_DEF_CL}};
            s_q.locked <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o           = s_q.rdat;
    assign ack_o           = s_q.ack;
    assign voltage_cmd_o   = s_q.volt[17:2];
    assign current_limit_o = s_q.climit;
    assign running_o       = (s_q.st != SSR_IDLE);
    assign trip_o          = s_q.trip;
    assign status_msg_o    = s_q.msg;
    assign thermal_cap_o   = 7'd100 - s_q.heat;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence pw_write;
        wr && adr_i == `SSR_OFF_PASSWORD;
    endsequence

    chk_lockout_refuse: assert property (s_q.st == SSR_IDLE && start_s && lock_any |=>
        s_q.st == SSR_IDLE && s_q.msg == SSR_MSG_LOCKOUT)
        else $error("start accepted during lockout");
    chk_pass_ok: assert property (pw_write ##0 dat_i == {16'h0, PASSWORD} |=>
        !s_q.locked && s_q.msg == SSR_MSG_PASS_OK)
        else $error("good password not accepted");
    chk_pass_err: assert property (pw_write ##0 dat_i != {16'h0, PASSWORD} |=>
        s_q.locked && s_q.msg == SSR_MSG_PASS_ERR)
        else $error("bad password released lock");
    chk_memory_clear: assert property (wr_cfg && adr_i == `SSR_OFF_DEFCLR
        && dat_i == `SSR_DEFCLR_CLEAR |=> s_q.heat == 7'h0 && !lock_any
        && s_q.msg == SSR_MSG_CLEARED)
        else $error("memory clear incomplete");
    chk_cap_range: assert property (thermal_cap_o <= 7'd100)
        else $error("thermal capacity out of range");
    chk_limit_floor: assert property (s_q.ramp[0].cl >= `SSR_CL_MIN
        && s_q.ramp[1].cl >= `SSR_CL_MIN)
        else $error("current limit below floor");
    chk_atspeed_end: assert property (s_q.st == SSR_RAMP && atspd_s && start_s
        && !s_q.trip |=> s_q.st == SSR_RUN && !current_limit_o ##1 !current_limit_o)
        else $error("ramp not ended at speed");
    chk_trip_stop: assert property (s_q.st != SSR_IDLE && s_q.trip |=>
        !running_o && !current_limit_o && voltage_cmd_o == 16'h0)
        else $error("drive kept after trip");
    chk_vramp_hold: assert property (s_q.st == SSR_RAMP && !s_q.cmode && at_limit
        && start_s && !atspd_s && !s_q.trip |=> $stable(s_q.volt) && current_limit_o)
        else $error("voltage rose while at limit");
    chk_tripped_msg: assert property (s_q.st == SSR_IDLE && start_s && s_q.trip
        && !lock_any ##1 !start_s && s_q.msg == SSR_MSG_TRIPPED |=>
        s_q.msg == SSR_MSG_FAULT || wr)
        else $error("fault not shown after start removed");

endmodule : ssr_top
`default_nettype wire

// ===== ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// Byte offsets on the register bus
`define SSR_OFF_TYPE      8'h00
`define SSR_OFF_R1_IV     8'h04
`define SSR_OFF_R1_IC     8'h08
`define SSR_OFF_R1_TIME   8'h0c
`define SSR_OFF_R1_CL     8'h10
`define SSR_OFF_R2_IV     8'h14
`define SSR_OFF_R2_IC     8'h18
`define SSR_OFF_R2_TIME   8'h1c
`define SSR_OFF_R2_CL     8'h20
`define SSR_OFF_DEFCLR    8'h24
`define SSR_OFF_PASSWORD  8'h28
`define SSR_OFF_LOCK0     8'h2c
`define SSR_OFF_LOCK1     8'h30
`define SSR_OFF_LOCK2     8'h34
`define SSR_OFF_STATUS    8'h38
`define SSR_OFF_THERMAL   8'h3c
`define SSR_OFF_OUTPUT    8'h40
`define SSR_OFF_TRIPRST   8'h44

// Field positions in the status word
`define SSR_ST_LOCKED     8
`define SSR_ST_TRIP       9
`define SSR_ST_CLIMIT     10
`define SSR_ST_SEL2       11
`define SSR_ST_VTYPE      12

// Reset and factory default values, then the restore and clear command codes
`define SSR_DEF_TYPE      3'h1
`define SSR_DEF_IV        10'h014
`define SSR_DEF_IC        10'h0c8
`define SSR_DEF_TIME      16'h2710
`define SSR_DEF_CL        10'h15e
`define SSR_DEFCLR_RESTORE 32'h0000_0001
`define SSR_DEFCLR_CLEAR  32'h0000_0002

// Limits, in percent of full load current or full voltage, except ramp time in ticks and loop gain as a shift
`define SSR_FULL          10'h064
`define SSR_CL_MIN        10'h0c8
`define SSR_CL_MAX        10'h258
`define SSR_TIME_MIN      16'h0001
`define SSR_KP_SHIFT      4

// Control tick: time in ns, clock period in ns, count derived
`define SSR_TICK_NS       1000000
`define SSR_CLK_NS        8
`define SSR_TICK_CYC      (`SSR_TICK_NS / `SSR_CLK_NS)

`endif

// ===== ssr_pkg.sv
package ssr_pkg;

    typedef enum logic [1:0] {
        SSR_IDLE,
        SSR_RAMP,
        SSR_RUN
    } ssr_state_t;

    typedef enum logic [3:0] {
        SSR_MSG_NONE,
        SSR_MSG_LOCKOUT,
        SSR_MSG_PASS_OK,
        SSR_MSG_PASS_ERR,
        SSR_MSG_CHANGE_OK,
        SSR_MSG_DEFAULTS,
        SSR_MSG_TRIPPED,
        SSR_MSG_FAULT,
        SSR_MSG_CLEARED,
        SSR_MSG_INHIBIT
    } ssr_msg_t;

    typedef struct packed {
        logic [9:0]  iv;
        logic [9:0]  ic;
        logic [15:0] rtime;
        logic [9:0]  cl;
    } ssr_ramp_t;

    typedef struct packed {
        ssr_state_t           st;
        ssr_msg_t             msg;
        logic                 ack;
        logic [31:0]          rdat;
        logic [2:0]           rtype;
        ssr_ramp_t [1:0]      ramp;
        logic                 locked;
        logic [2:0][15:0]     lock;
        logic [6:0]           heat;
        logic [6:0]           heat_start;
        logic [6:0]           req_cap;
        logic                 trip;
        logic [2:0]           sy1;
        logic [2:0]           sy2;
        logic                 sel2;
        logic                 vtype;
        logic                 cmode;
        logic                 climit;
        logic [19:0]          rref;
        logic [19:0]          inc;
        logic [19:0]          tgt;
        logic [19:0]          volt;
        logic [31:0]          tick;
    } ssr_state_reg_t;

endpackage : ssr_pkg

// ===== ssr_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_motor_model (
    input  wire logic        clk_i,
    input  wire logic        start_req_i,
    input  wire logic        sel2_req_i,
    input  wire logic        speed_req_i,
    input  wire logic [2:0]  load_i,
    input  wire logic [15:0] voltage_cmd_i,
    output var logic         start_cmd_o = 1'b0,
    output var logic         ramp2_sel_o = 1'b0,
    output var logic         at_speed_o = 1'b0,
    output var logic [9:0]   motor_current_o = 10'h000
);
    logic [12:0] amps;
    // Current follows voltage times load, clipped to the sensor range
    assign amps = 13'(voltage_cmd_i[15:6]) * 13'(load_i);
    always @(posedge clk_i) begin
        start_cmd_o     <= start_req_i;
        ramp2_sel_o     <= sel2_req_i;
        at_speed_o      <= speed_req_i;
        motor_current_o <= (amps > 13'h3ff) ? 10'h3ff : amps[9:0];
    end
endmodule : ssr_motor_model
`default_nettype wire

// ===== ssr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssr_top_tb;
    import ssr_pkg::*;
    localparam logic [15:0] PW = 16'h1e2d; // Arbitrary value
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, st = 0, s2 = 0, spd = 0;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0, msg;
    logic [31:0] dat = 0, rq, dat_o;
    logic [2:0]  load = 0;
    logic        sc, r2, asp, ack_o, climit, running, trip;
    logic [9:0]  amps;
    logic [15:0] volt, t;
    logic [6:0]  cap;
    int          miscompares = 0, checked = 0, n;
    always #4 clk_i = ~clk_i;
    ssr_top #(.TICK_CYCLES(4), .PASSWORD(PW)) dut_u (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o, .ack_o, .start_cmd_i(sc),
        .ramp2_sel_i(r2), .at_speed_i(asp), .motor_current_i(amps), .voltage_cmd_o(volt),
        .current_limit_o(climit), .running_o(running), .trip_o(trip), .status_msg_o(msg),
        .thermal_cap_o(cap));
    ssr_motor_model mot_u (.clk_i, .start_req_i(st), .sel2_req_i(s2), .speed_req_i(spd),
        .load_i(load), .voltage_cmd_i(volt), .start_cmd_o(sc), .ramp2_sel_o(r2),
        .at_speed_o(asp), .motor_current_o(amps));
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic lim();
        if (n >= 1000) begin
            chk("wait bound", 0, 1);
            conclude();
        end
    endtask : lim
    task automatic cy(input int k);
        repeat (k) @(posedge clk_i);
    endtask : cy
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        for (n = 0; n < 1000 && ack_o !== 1'b1; n++) @(posedge clk_i);
        rq = dat_o;
        cyc <= 0;
        stb <= 0;
        lim();
    endtask : wb
    task automatic wm(input logic [7:0] a, input logic [31:0] d, input logic [3:0] e);
        wb(1, a, d);
        cy(1);
        chk("message", msg, e);
    endtask : wm
    // Ramp set one is voltage for types 1 and 3, set two for types 1 and 4
    function automatic logic vt(input int k, input logic s);
        return s ? (k == 1 || k == 4) : (k == 1 || k == 3);
    endfunction : vt
    initial begin
        void'($urandom(32'h9c7159a9));
        cy(4);
        rst_i <= 0;
        cy(1);
        chk("capacity", cap, 100);
        wb(0, 8'hfc, 0);
        chk("unmapped", rq, 0);
        wm(8'h28, {16'h0, PW ^ 16'($urandom_range(255, 1))}, SSR_MSG_PASS_ERR);
        wm(8'h0c, 5, SSR_MSG_INHIBIT);
        wm(8'h28, {16'h0, PW}, SSR_MSG_PASS_OK);
        t = 16'($urandom_range(8, 3));
        wm(8'h0c, {16'h0, t}, SSR_MSG_CHANGE_OK);
        wb(0, 8'h0c, 0);
        chk("ramp time", rq, {16'h0, t});
        wm(8'h24, 1, SSR_MSG_DEFAULTS);
        wb(0, 8'h0c, 0);
        chk("ramp time", rq, 32'h2710);
        wm(8'h10, $urandom_range(199, 100), SSR_MSG_INHIBIT);
        wb(0, 8'h10, 0);
        chk("limit", rq, 32'h15e);
        wb(1, 8'h0c, {16'h0, t});
        wb(1, 8'h1c, {16'h0, t});
        wb(1, 8'h14, 30);
        wb(1, 8'h10, 32'h258);
        wb(1, 8'h20, 32'h258);
        $display("test parameters done");
        wb(1, 8'h2c, 200);
        st <= 1;
        cy(8);
        chk("running", running, 0);
        chk("message", msg, SSR_MSG_LOCKOUT);
        wb(0, 8'h2c, 0);
        chk("lockout left", rq != 0, 1);
        st <= 0;
        cy(4);
        wm(8'h24, 2, SSR_MSG_CLEARED);
        wb(0, 8'h2c, 0);
        chk("lockout left", rq, 0);
        $display("test lockout done");
        for (int k = 1; k <= 4; k++) begin
            s2 <= 1'($urandom);
            wb(1, 8'h00, k);
            st <= 1;
            for (n = 0; n < 1000 && running !== 1'b1; n++) @(posedge clk_i);
            lim();
            if (vt(k, s2)) chk("initial volt", volt, s2 ? 16'd1920 : 16'd1280);
            spd <= 1;
            cy(8);
            chk("full volt", volt, 16'h1900);
            chk("limiting", climit, 0);
            wb(0, 8'h38, 0);
            chk("volt type", rq[12], vt(k, s2));
            chk("set two", rq[11], s2);
            chk("state", rq[5:4], 2);
            st  <= 0;
            spd <= 0;
            cy(8);
        end
        $display("test ramp types done");
        s2 <= 0;
        wb(1, 8'h04, 100);
        wb(1, 8'h08, 32'h258);
        wb(1, 8'h0c, 1);
        for (int k = 1; k <= 2; k++) begin
            wb(1, 8'h00, k);
            st <= 1;
            cy(8);
            chk("step limit", climit, 1);
            st <= 0;
            cy(8);
        end
        wb(1, 8'h04, 20);
        wb(1, 8'h0c, {16'h0, t});
        $display("test step start done");
        s2 <= 0;
        wb(1, 8'h00, 1);
        wb(1, 8'h10, 32'hc8);
        load <= 4;
        st   <= 1;
        for (n = 0; n < 1000 && climit !== 1'b1; n++) @(posedge clk_i);
        lim();
        chk("held volt", volt < 16'h1900, 1);
        load <= 1;
        for (n = 0; n < 1000 && volt !== 16'h1900; n++) @(posedge clk_i);
        lim();
        chk("limiting", climit, 0);
        $display("test current limit done");
        load <= 7;
        for (n = 0; n < 1000 && trip !== 1'b1; n++) @(posedge clk_i);
        lim();
        cy(2);
        chk("capacity", cap, 0);
        chk("limiting", climit, 0);
        st <= 0;
        cy(8);
        st <= 1;
        cy(8);
        chk("message", msg, SSR_MSG_TRIPPED);
        st <= 0;
        cy(8);
        chk("message", msg, SSR_MSG_FAULT);
        cy(40);
        chk("cooling", cap != 0, 1);
        wb(1, 8'h44, 0);
        cy(1);
        chk("trip", trip, 0);
        $display("test trip done");
        conclude();
    end
endmodule : ssr_top_tb
`default_nettype wire
